// ---- cdcmc_pkg.sv ----
// Constants and carriers for the converter mode and comparator setup block.
// Assumes one core clock and a register port driven by the serial interface logic.
package cdcmc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] CDCMC_CFG_OFFSET   = 8'h0f; // Converter configuration
  localparam logic [7:0] CDCMC_SETUP_OFFSET = 8'h0e; // Comparator setup
  localparam logic [7:0] CDCMC_CFG_RESET    = 8'h19; // Adaptive negative, enabled, continuous
  localparam logic [7:0] CDCMC_SETUP_RESET  = 8'h00; // Hysteresis on, fastest settling
  // ==========================================================
  // Converter mode encodings
  localparam logic [2:0] CDCMC_MODE_IDLE   = 3'h0; // Powered, no conversions
  localparam logic [2:0] CDCMC_MODE_CONT   = 3'h1; // Back to back conversions
  localparam logic [2:0] CDCMC_MODE_SINGLE = 3'h2; // One conversion then idle
  localparam logic [2:0] CDCMC_MODE_PDOWN  = 3'h3; // Front end powered down
  // ==========================================================
  // Comparator mode encodings
  localparam logic [1:0] CDCMC_CMP_NEG  = 2'h0; // Below
  localparam logic [1:0] CDCMC_CMP_POS  = 2'h1; // Above
  localparam logic [1:0] CDCMC_CMP_IN   = 2'h2; // Inside band
  localparam logic [1:0] CDCMC_CMP_OUT  = 2'h3; // Outside band
  // Average fraction bits and settling shift offset
  localparam int unsigned CDCMC_AVG_FRAC   = 16; // Fraction bits of running average
  localparam logic [4:0]  CDCMC_SHIFT_BASE = 5'h01; // Settling 2^(field+1) conversions
  // ==========================================================
  // Register layouts
  typedef struct packed {
    logic       fixed_threshold_select; // 1 = fixed threshold
    logic       comparator_mode_hi;     // Comparator mode msb
    logic       comparator_mode_lo;     // Comparator mode lsb
    logic       conversion_enable;      // Gates conversions
    logic       reserved3;              // Stored, unused
    logic       converter_mode_bit2;    // Reserved encodings when set
    logic       converter_mode_bit1;
    logic       converter_mode_bit0;
  } cdcmc_cfg_t;
  typedef struct packed {
    logic [1:0] upper;                  // Stored, owned by neighbour logic
    logic       reserved5;              // Stored, unused
    logic       hysteresis_disable;     // 1 = no hysteresis in adaptive mode
    logic [3:0] average_settling_select;// Settling speed of the average
  } cdcmc_setup_t;
  typedef enum logic {CDCMC_ST_IDLE, CDCMC_ST_BUSY} cdcmc_fsm_t;
  // Whole block state
  typedef struct packed {
    cdcmc_cfg_t   cfg;
    cdcmc_setup_t setup;
    cdcmc_fsm_t   fsm;
    logic [31:0]  avg;       // Running average, 16.16
    logic         avg_valid; // First result seen
    logic         flag;      // Comparator output
    logic         start;     // Conversion start pulse
    logic         pdown;     // Front end power down
    logic [7:0]   rdata;     // Read data
  } cdcmc_state_t;
endpackage

// ---- cdcmc_top.sv ----
// Converter mode sequencing, exponential average and output comparator.
// Assumes all inputs come from logic on CORE_CLK; the register port is fed
// by the serial interface, which stays clocked even in power down.
//
// Contract
// - Hysteresis bit set disables adaptive hysteresis
// - Fixed threshold always compares without hysteresis
// - Settling field sets average settle 2..65536
// - Fixed select chooses threshold or running average
// - Modes 00/01 flag below or above
// - Modes 10/11 flag inside or outside band; with fixed threshold they never flag
// - Idle mode starts no conversions
// - Continuous mode converts back to back
// - Single mode converts once, then idles
// - Power down stops all but serial interface
// - Configuration at 0x0f resets to 0x19
// - Configuration write of a mode other than power down leaves power down
module cdcmc_top #(
  parameter int DATA_W = 16
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RESET,
  input  wire logic [7:0]        REG_ADDR,
  input  wire logic              REG_WRITE,
  input  wire logic [7:0]        REG_WDATA,
  output logic      [7:0]        REG_RDATA,
  input  wire logic              CONV_DONE,
  input  wire logic [DATA_W-1:0] CONV_DATA,
  input  wire logic [DATA_W-1:0] THRESHOLD,
  input  wire logic [DATA_W-1:0] SENSITIVITY,
  input  wire logic [DATA_W-1:0] HYSTERESIS,
  input  wire logic              POWERDOWN_REQUEST,
  output logic                   CONV_START,
  output logic                   FRONTEND_POWER_DOWN,
  output logic      [DATA_W-1:0] AVERAGE,
  output logic                   COMPARE_FLAG
);
  // ==========================================================
  // State
  cdcmc_pkg::cdcmc_state_t s_reg;   // Registered state
  cdcmc_pkg::cdcmc_state_t s_next;  // Next state
  logic [2:0]              mode;    // Current converter mode
  logic [1:0]              cmp;     // Current comparator mode
  logic                    result;  // A conversion result arrives now
  logic                    hyst_on; // Hysteresis applies
  logic signed [DATA_W+2:0] d_s, avg_s, lo_s, hi_s, m_s, thr_s; // Compare operands
  logic signed [32:0]      diff;    // Data minus average, 16.16
  logic [4:0]              shift;   // Average shift
  logic                    hit;     // Comparator decision

  assign mode   = {s_reg.cfg.converter_mode_bit2, s_reg.cfg.converter_mode_bit1,
                   s_reg.cfg.converter_mode_bit0};
  assign cmp    = {s_reg.cfg.comparator_mode_hi, s_reg.cfg.comparator_mode_lo};
  assign result = (s_reg.fsm == cdcmc_pkg::CDCMC_ST_BUSY) && CONV_DONE;

  // ==========================================================
  // Comparator operands; extra headroom keeps average minus sensitivity signed
  always_comb
  begin
    d_s   = signed'({3'h0, CONV_DATA});
    avg_s = signed'({3'h0, s_reg.avg[31:cdcmc_pkg::CDCMC_AVG_FRAC]});
    thr_s = signed'({3'h0, THRESHOLD});
    lo_s  = avg_s - signed'({3'h0, SENSITIVITY});
    hi_s  = avg_s + signed'({3'h0, SENSITIVITY});
    // Fixed mode never uses hysteresis, adaptive only while bit is clear
    hyst_on = !s_reg.cfg.fixed_threshold_select
              && !s_reg.setup.hysteresis_disable;
    // Margin holds an active flag until data clears the band by the hysteresis
    m_s = (hyst_on && s_reg.flag) ? signed'({3'h0, HYSTERESIS}) : '0;
    hit = 1'b0;
    if (s_reg.cfg.fixed_threshold_select)
    begin
      // Compare against programmed threshold
      unique case (cmp)
        cdcmc_pkg::CDCMC_CMP_NEG: hit = d_s < thr_s;
        cdcmc_pkg::CDCMC_CMP_POS: hit = d_s > thr_s;
        default:                  hit = 1'b0;              // Window undefined
      endcase
    end
    else
    begin
      // Compare against running average band
      unique case (cmp)
        cdcmc_pkg::CDCMC_CMP_NEG: hit = d_s < lo_s + m_s;
        cdcmc_pkg::CDCMC_CMP_POS: hit = d_s > hi_s - m_s;
        cdcmc_pkg::CDCMC_CMP_IN:  hit = (d_s > lo_s - m_s) && (d_s < hi_s + m_s);
        cdcmc_pkg::CDCMC_CMP_OUT: hit = (d_s < lo_s + m_s) || (d_s > hi_s - m_s);
      endcase
    end
  end

  // ==========================================================
  // Next state: sequencing, average, registers
  always_comb
  begin
    s_next       = s_reg;
    s_next.start = 1'b0;
    // Settling of 2^(field+1) conversions maps to a shift of field+1
    shift = cdcmc_pkg::CDCMC_SHIFT_BASE + {1'b0, s_reg.setup.average_settling_select};
    diff  = signed'({1'b0, CONV_DATA, 16'h0000}) - signed'({1'b0, s_reg.avg});
    unique case (s_reg.fsm)
      cdcmc_pkg::CDCMC_ST_IDLE:
      begin
        // Idle and power down start nothing; enable gates the rest
        if (s_reg.cfg.conversion_enable
            && (mode == cdcmc_pkg::CDCMC_MODE_CONT || mode == cdcmc_pkg::CDCMC_MODE_SINGLE))
        begin
          s_next.start = 1'b1;
          s_next.fsm   = cdcmc_pkg::CDCMC_ST_BUSY;
        end
      end
      cdcmc_pkg::CDCMC_ST_BUSY:
      begin
        if (CONV_DONE)
        begin
          // Flag follows results only
          s_next.flag      = hit;
          s_next.avg_valid = 1'b1;
          // First result seeds the average, later ones decay toward data
          if (!s_reg.avg_valid)
            s_next.avg = {CONV_DATA, 16'h0000};
          else
            s_next.avg = s_reg.avg + 32'(diff >>> shift);
          // Single shot falls back to idle by itself
          if (mode == cdcmc_pkg::CDCMC_MODE_SINGLE)
            {s_next.cfg.converter_mode_bit2, s_next.cfg.converter_mode_bit1,
             s_next.cfg.converter_mode_bit0} = cdcmc_pkg::CDCMC_MODE_IDLE;
          // Back to idle; restarts next cycle in continuous mode
          s_next.fsm = cdcmc_pkg::CDCMC_ST_IDLE;
        end
        else if (!s_reg.cfg.conversion_enable
                 || (mode != cdcmc_pkg::CDCMC_MODE_CONT && mode != cdcmc_pkg::CDCMC_MODE_SINGLE))
          // Mode left mid conversion, the pending result is dropped
          s_next.fsm = cdcmc_pkg::CDCMC_ST_IDLE;
      end
    endcase
    // Power down timer request from neighbouring logic
    if (POWERDOWN_REQUEST)
      {s_next.cfg.converter_mode_bit2, s_next.cfg.converter_mode_bit1,
       s_next.cfg.converter_mode_bit0} = cdcmc_pkg::CDCMC_MODE_PDOWN;
    // Host writes last so they win over hardware mode changes
    if (REG_WRITE && REG_ADDR == cdcmc_pkg::CDCMC_CFG_OFFSET)
      s_next.cfg = cdcmc_pkg::cdcmc_cfg_t'(REG_WDATA);
    if (REG_WRITE && REG_ADDR == cdcmc_pkg::CDCMC_SETUP_OFFSET)
      s_next.setup = cdcmc_pkg::cdcmc_setup_t'(REG_WDATA);
    // Front end off only in the power down code
    s_next.pdown = ({s_next.cfg.converter_mode_bit2, s_next.cfg.converter_mode_bit1,
                     s_next.cfg.converter_mode_bit0} == cdcmc_pkg::CDCMC_MODE_PDOWN);
    // A start launched as power down lands would hit a dead front end
    if (s_next.pdown)
    begin
      s_next.start = 1'b0;
      s_next.fsm   = cdcmc_pkg::CDCMC_ST_IDLE;
    end
    // Read data, one cycle after the address; unmapped reads zero
    if (REG_ADDR == cdcmc_pkg::CDCMC_CFG_OFFSET)
      s_next.rdata = s_reg.cfg;
    else if (REG_ADDR == cdcmc_pkg::CDCMC_SETUP_OFFSET)
      s_next.rdata = s_reg.setup;
    else
      s_next.rdata = 8'h00;
  end

  // ==========================================================
  // State register
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      s_reg       <= '0;
      s_reg.cfg   <= cdcmc_pkg::CDCMC_CFG_RESET;
      s_reg.setup <= cdcmc_pkg::CDCMC_SETUP_RESET;
    end
    else
      s_reg <= s_next;
  end

  // Outputs straight from flops
  assign REG_RDATA           = s_reg.rdata;
  assign CONV_START          = s_reg.start;
  assign FRONTEND_POWER_DOWN = s_reg.pdown;
  assign AVERAGE             = s_reg.avg[31:cdcmc_pkg::CDCMC_AVG_FRAC];
  assign COMPARE_FLAG        = s_reg.flag;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  logic no_wr; // No host or timer action this cycle
  assign no_wr = !REG_WRITE && !POWERDOWN_REQUEST;
  sequence seq_result;
    result && no_wr;
  endsequence
  sequence seq_cont_done;
    seq_result ##0 (mode == cdcmc_pkg::CDCMC_MODE_CONT) && s_reg.cfg.conversion_enable;
  endsequence

  a_reset_config: assert property ($fell(RESET) |-> s_reg.cfg == 8'h19)
    else $error("Configuration reset value wrong");
  a_idle_silent: assert property (mode == cdcmc_pkg::CDCMC_MODE_IDLE && no_wr
    |=> !CONV_START) else $error("Start issued in idle");
  a_cont_restart: assert property (seq_cont_done ##1 no_wr |=> CONV_START)
    else $error("Continuous mode did not restart");
  a_single_idle: assert property (seq_result ##0 mode == cdcmc_pkg::CDCMC_MODE_SINGLE
    |=> mode == cdcmc_pkg::CDCMC_MODE_IDLE ##1 !CONV_START)
    else $error("Single conversion did not idle");
  a_pdown_out: assert property (mode == cdcmc_pkg::CDCMC_MODE_PDOWN
    |-> FRONTEND_POWER_DOWN && !CONV_START) else $error("Power down not applied");
  a_flag_hold: assert property (!result |=> $stable(COMPARE_FLAG))
    else $error("Flag moved without result");
  a_fixed_neg: assert property (seq_result ##0 s_reg.cfg.fixed_threshold_select
    && cmp == cdcmc_pkg::CDCMC_CMP_NEG |=> COMPARE_FLAG == $past(d_s < thr_s))
    else $error("Fixed negative compare wrong");
  a_fixed_window: assert property (seq_result ##0 s_reg.cfg.fixed_threshold_select
    && s_reg.cfg.comparator_mode_hi |=> !COMPARE_FLAG)
    else $error("Window mode active in fixed threshold");
  a_adapt_pos: assert property (seq_result ##0 !s_reg.cfg.fixed_threshold_select
    && cmp == cdcmc_pkg::CDCMC_CMP_POS && d_s > hi_s |=> COMPARE_FLAG)
    else $error("Adaptive positive compare missed");
  a_hyst_off: assert property (seq_result ##0 !s_reg.cfg.fixed_threshold_select
    && s_reg.setup.hysteresis_disable && cmp == cdcmc_pkg::CDCMC_CMP_NEG && d_s >= lo_s
    |=> !COMPARE_FLAG) else $error("Hysteresis applied while disabled");
  a_avg_settle: assert property (seq_result ##0 s_reg.avg_valid
    && s_reg.avg[15:0] == 16'h0000 && CONV_DATA == AVERAGE |=> $stable(AVERAGE))
    else $error("Settled average drifted");
endmodule

// ---- cdcmc_fe_model.sv ----
// Behavioural front end: answers each conversion start after a fixed latency.
// Assumes start pulses come from the block under test on the same clock.
module cdcmc_fe_model #(
  parameter int LAT = 3
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [15:0] data_in,
  output logic             done,
  output logic      [15:0] data
);
  int cnt; // Cycles left of a pending conversion, 0 = none
  // ==========================================================
  // Latency counter and result pulse
  // Data toggles outside the result cycle so a stale value never looks valid
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 0;
      done <= 1'b0;
      data <= 16'h0000;
    end
    else
    begin
      done <= (cnt == 1);
      data <= (cnt == 1) ? data_in : ~data;
      if (start)
        cnt <= LAT;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule

// ---- cdcmc_top_tb.sv ----
// Self-checking bench for converter mode and comparator configuration.
// Assumes the front end model stands on the conversion link.
module cdcmc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CORE_CLK = 1'b0, RESET = 1'b1, REG_WRITE = 1'b0, PDR = 1'b0;
  logic [7:0]  REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, rv;
  logic [15:0] fe_in = 16'h1000, CONV_DATA, AVERAGE;
  logic        CONV_DONE, CONV_START, PD, FLAG;
  int          error_cnt = 0, checks = 0, start_cnt = 0, cyc = 0, s;
  // ==========================================================
  // Step table: config, setup, data, flag, average (0 = not checked)
  // Last three: slowest settling freezes the average, hysteresis on then off
  localparam logic [7:0]  CFG_T [0:12] = '{8'h52, 8'h32, 8'h12, 8'h72, 8'h52,
                                           8'h12, 8'h92, 8'h92, 8'hb2, 8'hd2,
                                           8'h12, 8'h12, 8'h12};
  localparam logic [7:0]  SET_T [0:12] = '{8'h10, 8'h10, 8'h13, 8'h10, 8'h10,
                                           8'h10, 8'h00, 8'h00, 8'h00, 8'h00,
                                           8'h0f, 8'h0f, 8'h1f};
  localparam logic [15:0] DAT_T [0:12] = '{16'h1000, 16'h2000, 16'h2800, 16'h0100,
                                           16'h0d00, 16'h0c00, 16'h0fff, 16'h1000,
                                           16'h1001, 16'h1000, 16'h0f00, 16'h0fc0,
                                           16'h0fc0};
  localparam logic        FLG_T [0:12] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1,
                                           1'b1, 1'b1, 1'b0, 1'b1, 1'b0,
                                           1'b1, 1'b1, 1'b0};
  localparam logic [15:0] AVG_T [0:12] = '{16'h1000, 16'h1800, 16'h1900, 16'h0d00,
                                           16'h0d00, 16'h0c80, 16'h0000, 16'h0000,
                                           16'h0000, 16'h0000, 16'h0fc8, 16'h0fc8,
                                           16'h0fc8};
  // ==========================================================
  // Clock, start counter and hang guard
  always #50 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK)
  begin
    cyc++;
    if (CONV_START === 1'b1)
      start_cnt++;
    if (cyc == 5000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  cdcmc_top i_dut (.CORE_CLK(CORE_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
    .REG_WRITE(REG_WRITE), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA), .THRESHOLD(16'h1000),
    .SENSITIVITY(16'h0010), .HYSTERESIS(16'h0040), .POWERDOWN_REQUEST(PDR),
    .CONV_START(CONV_START), .FRONTEND_POWER_DOWN(PD), .AVERAGE(AVERAGE),
    .COMPARE_FLAG(FLAG));
  cdcmc_fe_model i_fe (.clk(CORE_CLK), .rst(RESET), .start(CONV_START),
    .data_in(fe_in), .done(CONV_DONE), .data(CONV_DATA));
  // ==========================================================
  // Helpers: all driving happens at the falling edge
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WRITE = 1'b1;
    wt(1);
    REG_WRITE = 1'b0;
    // Strobe rests a cycle so back to back writes never retoggle it at once
    wt(1);
  endtask
  // Read data is registered, so it is taken one cycle after the address
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    REG_ADDR = a;
    wt(1);
    chk({8'h00, REG_RDATA}, {8'h00, e});
  endtask
  task automatic quiet(); // No starts over a long idle stretch
    wt(8);
    s = start_cnt;
    wt(20);
    chk(16'(start_cnt - s), 16'h0000);
  endtask
  task automatic stop_test();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    wt(6);
    RESET = 1'b0;
    rc(8'h0f, 8'h19);
    rc(8'h0e, 8'h00);
    rc(8'h20, 8'h00);
    wr(8'h20, 8'hff);
    rc(8'h0f, 8'h19);
    wt(40);
    chk({15'h0, start_cnt > 5}, 16'h0001);
    wr(8'h0f, 8'h01);
    quiet();
    wr(8'h0f, 8'h10);
    quiet();
    chk({15'h0, FLAG}, 16'h0000);
    wr(8'h0f, 8'h13);
    wt(2);
    chk({15'h0, PD}, 16'h0001);
    quiet();
    rc(8'h0f, 8'h13);
    wr(8'h0f, 8'h10);
    wt(2);
    chk({15'h0, PD}, 16'h0000);
    PDR = 1'b1;
    wt(1);
    PDR = 1'b0;
    wt(2);
    chk({15'h0, PD}, 16'h0001);
    rc(8'h0f, 8'h13);
    wr(8'h0f, 8'h10);
    // Single conversions through every comparator mode
    for (int i = 0; i < 13; i++)
    begin
      fe_in = DAT_T[i];
      wr(8'h0e, SET_T[i]);
      s = start_cnt;
      wr(8'h0f, CFG_T[i]);
      for (int k = 0; k < 40 && CONV_DONE !== 1'b1; k++)
        wt(1);
      wt(1);
      chk({15'h0, FLAG}, {15'h0, FLG_T[i]});
      if (AVG_T[i] != 16'h0000)
        chk(AVERAGE, AVG_T[i]);
      wt(8);
      chk(16'(start_cnt - s), 16'h0001);
      rc(8'h0f, {CFG_T[i][7:3], 3'h0});
      chk({15'h0, FLAG}, {15'h0, FLG_T[i]});
    end
    stop_test();
  end
endmodule
